// >>> mkp_params.svh
// offsets, field positions, reset values and timing counts of the matrix key panel scanner
`ifndef MKP_PARAMS_SVH
`define MKP_PARAMS_SVH

// ----------------------------------------------------------------------------
// matrix geometry
// ----------------------------------------------------------------------------
`define MKP_NUM_COMMONS 12
`define MKP_NUM_DATA 8
`define MKP_PIN_SYNC_W 37

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define MKP_CLK_PERIOD_NS 4
`define MKP_SLOT_NS 1000
`define MKP_SLOT_CYCLES ((`MKP_SLOT_NS + `MKP_CLK_PERIOD_NS - 1) / `MKP_CLK_PERIOD_NS)
`define MKP_TONE_MS 50
`define MKP_TONE_CYCLES (`MKP_TONE_MS * 1000000 / `MKP_CLK_PERIOD_NS)
`define MKP_BLINK_MS 250
`define MKP_BLINK_CYCLES (`MKP_BLINK_MS * 1000000 / `MKP_CLK_PERIOD_NS)
`define MKP_STRAP_WAIT 2'h3

// ----------------------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------------------
`define MKP_OFS_CTRL 12'h000
`define MKP_OFS_STATUS 12'h004
`define MKP_OFS_MASK 12'h008
`define MKP_OFS_METER 12'h00C
`define MKP_OFS_STATE 12'h010
`define MKP_OFS_KEY_BASE 12'h040
`define MKP_KEY_REGION 6'h01

// ----------------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------------
`define MKP_CTRL_RUN_BIT 0
`define MKP_CTRL_TONE_EN_BIT 7
`define MKP_CTRL_RST 8'h01
`define MKP_ST_PUBLISH_BIT 0
`define MKP_ST_GHOST_BIT 1
`define MKP_ST_TONE_BIT 2
`define MKP_METER_FULL 8'hF8
`define MKP_METER_FIELD_MAX 5'h1F

`endif

// >>> mkp_pkg.sv
// types shared by the matrix key panel scanner files
package mkp_pkg;

    typedef enum logic [1:0] {
        MKP_ST_HALT  = 2'b00,
        MKP_ST_SLOT  = 2'b01,
        MKP_ST_CHECK = 2'b10
    } mkp_state_e;

    typedef logic [7:0] mkp_word_t;

endpackage

// >>> mkp_key_mem.sv
// two-bank key image memory with one write port and two registered read ports
module mkp_key_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [AW-1:0] raddr_a,
    output logic [WIDTH-1:0] rdata_a,
    input wire logic [AW-1:0] raddr_b,
    output logic [WIDTH-1:0] rdata_b
);

    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // read data registered; a word written in the same cycle reads old data
    always_ff @(posedge clk) begin
        rdata_a <= mem[raddr_a];
        rdata_b <= mem[raddr_b];
    end

endmodule

// >>> mkp_scanner.sv
// matrix key panel scanner: key scan, ghost rejection, tone, meters, indicators, apb registers
`include "mkp_params.svh"

// Summary of operation
// R1: select line open: drop the whole matrix when three or more keys close.
// R2: a third key drops all three; releasing one restores the other two.
// R3: select line grounded: three simultaneous keys are accepted (external diodes).
// R4: tone enabled or disabled per group of eight keys sharing one common.
// R5: closure sounds tone if its common is unlinked from the group select.
// R6: host must set tone enable, bit 7 of control, before any tone.
// R7: tone only on a new closure, never on hold or release; held keys sound again after a rejected (blank) scan.
// R8: tone group links captured once after reset, later changes ignored.
// R9: load and speed meter values reported as five-bit codes.
// R10: input above full scale reads as the full-scale code.
// R11: each five-bit meter code sits in bits 3 to 7 of its byte.
// R12: scan indicator blinks while scanning, holds steady when halted.
// R13: alarm indicator lit while an alarm stands, dark otherwise.
// R14: commons driven one at a time in order, all data lines sampled.
// R15: closures counted over a full scan, checked, then image published.
module mkp_scanner #(
    parameter int TONE_CYCLES = `MKP_TONE_CYCLES,
    parameter int BLINK_CYCLES = `MKP_BLINK_CYCLES,
    parameter int SLOT_CYCLES = `MKP_SLOT_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] key_data_line_n,
    output logic [11:0] key_common_line_n,
    input wire logic three_input_select_n,
    input wire logic [11:0] tone_group_link_n,
    input wire logic [7:0] load_meter_input,
    input wire logic [7:0] speed_meter_input,
    output logic tone_out,
    output logic scan_indicator,
    output logic alarm_indicator,
    output logic irq
);

    // ------------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------------
    logic [`MKP_PIN_SYNC_W-1:0] pin_raw;
    logic [`MKP_PIN_SYNC_W-1:0] pin_meta;
    logic [`MKP_PIN_SYNC_W-1:0] pin_sync;

    assign pin_raw = {speed_meter_input, load_meter_input, three_input_select_n, tone_group_link_n, key_data_line_n};

    genvar gi;
    generate
        for (gi = 0; gi < `MKP_PIN_SYNC_W; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pin_meta[gi] <= 1'b1;
                    pin_sync[gi] <= 1'b1;
                end else begin
                    pin_meta[gi] <= pin_raw[gi];
                    pin_sync[gi] <= pin_meta[gi];
                end
            end
        end
    endgenerate

    logic [7:0] data_closed;
    logic [11:0] link_sync_n;
    logic reject_mode;
    logic [7:0] load_sync;
    logic [7:0] speed_sync;

    // key data pins are active low: a closed key pulls its data line down
    assign data_closed = ~pin_sync[7:0];
    assign link_sync_n = pin_sync[19:8];
    assign reject_mode = pin_sync[20];
    assign load_sync = pin_sync[28:21];
    assign speed_sync = pin_sync[36:29];

    // ------------------------------------------------------------------------
    // registers and shared state
    // ------------------------------------------------------------------------
    mkp_pkg::mkp_state_e state;
    logic [3:0] cidx;
    logic [15:0] slot_cnt;
    logic [1:0] close_cnt;
    logic pub_bank;
    logic blank;
    logic ghost_hit;
    logic [7:0] ctrl;
    logic [2:0] status;
    logic [2:0] mask;
    logic [11:0] tone_group;
    logic captured;
    logic [1:0] strap_wait;
    logic [7:0] load_byte;
    logic [7:0] speed_byte;
    logic [7:0] load_prev;
    logic [7:0] speed_prev;
    logic [31:0] tone_cnt;
    logic [31:0] blink_cnt;
    mkp_pkg::mkp_word_t old_raw;
    mkp_pkg::mkp_word_t key_raw;

    logic run;
    logic tone_enable;
    logic slot_last;
    logic [4:0] close_sum;
    mkp_pkg::mkp_word_t old_word;
    mkp_pkg::mkp_word_t new_bits;
    logic tone_start;
    logic ghost;

    assign run = ctrl[`MKP_CTRL_RUN_BIT];
    assign tone_enable = ctrl[`MKP_CTRL_TONE_EN_BIT];
    assign slot_last = (state == mkp_pkg::MKP_ST_SLOT) && (slot_cnt == 16'(SLOT_CYCLES - 1));
    assign close_sum = 5'(close_cnt) + 5'($countones(data_closed));
    assign ghost = reject_mode && (close_cnt == 2'h3);

    // ------------------------------------------------------------------------
    // scan sequencer
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= mkp_pkg::MKP_ST_HALT;
            cidx <= 4'h0;
            slot_cnt <= 16'h0000;
            close_cnt <= 2'h0;
        end else begin
            case (state)
                mkp_pkg::MKP_ST_HALT: begin
                    cidx <= 4'h0;
                    slot_cnt <= 16'h0000;
                    close_cnt <= 2'h0;
                    if (run) begin
                        state <= mkp_pkg::MKP_ST_SLOT;
                    end
                end
                mkp_pkg::MKP_ST_SLOT: begin
                    if (slot_last) begin
                        slot_cnt <= 16'h0000;
                        // saturate at three: only "three or more" matters [R15]
                        close_cnt <= (close_sum >= 5'h03) ? 2'h3 : close_sum[1:0];
                        if (cidx == 4'(`MKP_NUM_COMMONS - 1)) begin
                            cidx <= 4'h0;
                            state <= mkp_pkg::MKP_ST_CHECK;
                        end else begin
                            cidx <= cidx + 4'h1; // [R14]
                        end
                    end else begin
                        slot_cnt <= slot_cnt + 16'h0001;
                    end
                end
                mkp_pkg::MKP_ST_CHECK: begin
                    close_cnt <= 2'h0;
                    state <= run ? mkp_pkg::MKP_ST_SLOT : mkp_pkg::MKP_ST_HALT;
                end
                default: begin
                    state <= mkp_pkg::MKP_ST_HALT;
                end
            endcase
        end
    end

    // one common low at a time; all high while halted [R14]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_common_line_n <= 12'hFFF;
        end else if (state == mkp_pkg::MKP_ST_SLOT) begin
            key_common_line_n <= ~(12'h001 << cidx);
        end else begin
            key_common_line_n <= 12'hFFF;
        end
    end

    // ------------------------------------------------------------------------
    // key image: scan fills the hidden bank, check flips banks
    // ------------------------------------------------------------------------
    mkp_key_mem #(
        .WIDTH(8),
        .DEPTH(32),
        .AW(5)
    ) u_mem (
        .clk(pclk),
        .we(slot_last),
        .waddr({~pub_bank, cidx}),
        .wdata(data_closed),
        .raddr_a({pub_bank, cidx}),
        .rdata_a(old_raw),
        .raddr_b({pub_bank, paddr[5:2]}),
        .rdata_b(key_raw)
    );

    // a rejected scan publishes an empty image without touching memory
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pub_bank <= 1'b0;
            blank <= 1'b1;
            ghost_hit <= 1'b0;
        end else if (state == mkp_pkg::MKP_ST_CHECK) begin
            pub_bank <= ~pub_bank; // [R15]
            blank <= ghost; // [R1] [R2] [R3]
            // blank is also set before the first scan; only a real rejection is an alarm
            ghost_hit <= ghost;
        end
    end

    // ------------------------------------------------------------------------
    // confirmation tone
    // ------------------------------------------------------------------------
    // tone group is a strap: caught once the synchronisers have settled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_wait <= 2'h0;
            captured <= 1'b0;
            tone_group <= 12'h000;
        end else if (!captured) begin
            if (strap_wait == `MKP_STRAP_WAIT) begin
                tone_group <= ~link_sync_n; // [R8]
                captured <= 1'b1;
            end else begin
                strap_wait <= strap_wait + 2'h1;
            end
        end
    end

    // compared against the last published image, so a held key stays silent unless that image was rejected (blank)
    assign old_word = blank ? 8'h00 : old_raw;
    assign new_bits = data_closed & ~old_word; // [R7]
    assign tone_start = slot_last && (|new_bits) && !tone_group[cidx] && tone_enable && captured; // [R4] [R5] [R6]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tone_cnt <= 32'h0;
            tone_out <= 1'b0;
        end else if (tone_start) begin
            tone_cnt <= 32'(TONE_CYCLES - 1);
            tone_out <= 1'b1; // [R7]
        end else if (tone_cnt != 32'h0) begin
            tone_cnt <= tone_cnt - 32'h1;
        end else begin
            tone_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // meters
    // ------------------------------------------------------------------------
    // a code crosses bit by bit, so it is taken only once two samples agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_prev <= 8'h00;
            speed_prev <= 8'h00;
        end else begin
            load_prev <= load_sync;
            speed_prev <= speed_sync;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_byte <= 8'h00;
            speed_byte <= 8'h00;
        end else begin
            if (load_sync == load_prev) begin
                load_byte <= {(load_sync > `MKP_METER_FULL) ? `MKP_METER_FIELD_MAX : load_sync[7:3],
                              3'h0}; // [R9] [R10] [R11]
            end
            if (speed_sync == speed_prev) begin
                speed_byte <= {(speed_sync > `MKP_METER_FULL) ? `MKP_METER_FIELD_MAX : speed_sync[7:3],
                               3'h0}; // [R9] [R10] [R11]
            end
        end
    end

    // ------------------------------------------------------------------------
    // indicators
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blink_cnt <= 32'h0;
            scan_indicator <= 1'b0;
        end else if (state != mkp_pkg::MKP_ST_HALT) begin
            if (blink_cnt == 32'(BLINK_CYCLES - 1)) begin
                blink_cnt <= 32'h0;
                scan_indicator <= ~scan_indicator; // [R12]
            end else begin
                blink_cnt <= blink_cnt + 32'h1;
            end
        end
    end

    // a rejected key image is the alarm condition
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_indicator <= 1'b0;
        end else begin
            alarm_indicator <= ghost_hit; // [R13]
        end
    end

    // ------------------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------------------
    logic acc_first;
    logic wr_fire;
    logic is_key;
    logic mapped;
    logic [31:0] rd_mux;
    logic [2:0] st_set;
    logic [2:0] st_clr;

    assign acc_first = psel && penable && !pready;
    assign wr_fire = psel && penable && pready && pwrite && !pslverr;
    assign is_key = (paddr[11:6] == `MKP_KEY_REGION) && (paddr[5:2] < 4'(`MKP_NUM_COMMONS)) && (paddr[1:0] == 2'h0);

    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0;
        if (is_key) begin
            rd_mux = blank ? 32'h0 : {24'h0, key_raw};
        end else begin
            case (paddr)
                `MKP_OFS_CTRL: rd_mux = {24'h0, ctrl};
                `MKP_OFS_STATUS: rd_mux = {29'h0, status};
                `MKP_OFS_MASK: rd_mux = {29'h0, mask};
                `MKP_OFS_METER: rd_mux = {16'h0, speed_byte, load_byte};
                `MKP_OFS_STATE: rd_mux = {16'h0, tone_group, 2'h0, blank, reject_mode};
                default: mapped = 1'b0;
            endcase
        end
    end

    // one wait cycle lets the registered memory read settle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= acc_first;
            pslverr <= acc_first && !mapped;
            if (acc_first) begin
                prdata <= (pwrite || !mapped) ? 32'h0 : rd_mux;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `MKP_CTRL_RST;
            mask <= 3'h0;
        end else if (wr_fire) begin
            if (paddr == `MKP_OFS_CTRL) begin
                ctrl <= pwdata[7:0]; // [R6]
            end
            if (paddr == `MKP_OFS_MASK) begin
                mask <= pwdata[2:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // interrupts: sticky, write one to clear, set beats clear
    // ------------------------------------------------------------------------
    assign st_set[`MKP_ST_PUBLISH_BIT] = (state == mkp_pkg::MKP_ST_CHECK);
    assign st_set[`MKP_ST_GHOST_BIT] = (state == mkp_pkg::MKP_ST_CHECK) && ghost;
    assign st_set[`MKP_ST_TONE_BIT] = tone_start;
    assign st_clr = (wr_fire && paddr == `MKP_OFS_STATUS) ? pwdata[2:0] : 3'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= 3'h0;
            irq <= 1'b0;
        end else begin
            status <= (status & ~st_clr) | st_set;
            irq <= |(status & mask);
        end
    end

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    property p_common_onehot;
        @(posedge pclk) disable iff (!presetn)
        (state == mkp_pkg::MKP_ST_SLOT && slot_cnt == 16'h0001) |-> (~key_common_line_n == (12'h001 << cidx));
    endproperty
    a_common_onehot: assert property (p_common_onehot) else $error("common line not one-hot"); // [R14]

    property p_ghost_drop;
        @(posedge pclk) disable iff (!presetn)
        (state == mkp_pkg::MKP_ST_CHECK && reject_mode && close_cnt == 2'h3) |=> blank ##1 alarm_indicator;
    endproperty
    a_ghost_drop: assert property (p_ghost_drop) else $error("ghost scan not rejected"); // [R1]

    property p_two_restored;
        @(posedge pclk) disable iff (!presetn)
        (state == mkp_pkg::MKP_ST_CHECK && close_cnt < 2'h3) |=> !blank;
    endproperty
    a_two_restored: assert property (p_two_restored) else $error("image not restored"); // [R2]

    property p_three_accepted;
        @(posedge pclk) disable iff (!presetn)
        (state == mkp_pkg::MKP_ST_CHECK && !reject_mode) |=> !blank;
    endproperty
    a_three_accepted: assert property (p_three_accepted) else $error("three keys dropped"); // [R3]

    property p_tone_gate;
        @(posedge pclk) disable iff (!presetn)
        tone_start |-> (tone_enable && !tone_group[cidx] && |(data_closed & ~old_word));
    endproperty
    a_tone_gate: assert property (p_tone_gate) else $error("tone without cause"); // [R5]

    property p_tone_len;
        @(posedge pclk) disable iff (!presetn)
        tone_start |=> tone_out [*3];
    endproperty
    a_tone_len: assert property (p_tone_len) else $error("tone too short"); // [R7]

    property p_strap_hold;
        @(posedge pclk) disable iff (!presetn)
        captured |=> $stable(tone_group) && captured;
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("tone group changed"); // [R8]

    property p_meter_clamp;
        @(posedge pclk) disable iff (!presetn)
        (load_sync > `MKP_METER_FULL && load_sync == load_prev) |=> (load_byte == 8'hF8);
    endproperty
    a_meter_clamp: assert property (p_meter_clamp) else $error("meter not clamped"); // [R10]

    property p_meter_field;
        @(posedge pclk) disable iff (!presetn)
        (speed_sync == speed_prev) |=> (speed_byte == {$past(speed_sync[7:3]), 3'h0} && load_byte[2:0] == 3'h0);
    endproperty
    a_meter_field: assert property (p_meter_field) else $error("meter field misplaced"); // [R11]

    property p_halt_steady;
        @(posedge pclk) disable iff (!presetn)
        (state == mkp_pkg::MKP_ST_HALT) |=> $stable(scan_indicator);
    endproperty
    a_halt_steady: assert property (p_halt_steady) else $error("indicator moved while halted"); // [R12]

    property p_alarm;
        @(posedge pclk) disable iff (!presetn)
        !ghost_hit |=> !alarm_indicator;
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm without cause"); // [R13]

endmodule

// >>> mkp_key_panel.sv
// key matrix panel model: closed keys pull data lines low on the active common
module mkp_key_panel (
    input wire logic [11:0] key_common_line_n,
    input wire logic [95:0] pressed,
    output logic [7:0] key_data_line_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // data lines carry pull-ups, so an open or unselected line reads high
    always_comb begin
        key_data_line_n = 8'hFF;
        for (int c = 0; c < 12; c++) begin
            if (!key_common_line_n[c]) begin
                key_data_line_n = key_data_line_n & ~pressed[c*8+:8];
            end
        end
    end
endmodule

// >>> tb.sv
// self-checking testbench of the matrix key panel scanner
`include "mkp_params.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SCAN = 12 * 8 + 1;
    localparam logic [11:0] KEY = `MKP_OFS_KEY_BASE;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sel_n = 1;
    logic pready, pslverr, tone, scan_ind, alarm, irq, er;
    logic [11:0] paddr = 0, link_n = 12'hFFE, kc_n;
    logic [31:0] pwdata = 0, prdata, rv;
    logic [7:0] kd_n, lm = 0, sm = 0;
    logic [95:0] keys = 0;
    int fails = 0, comparisons = 0, sc, tc;
    always #2 pclk = ~pclk;
    mkp_scanner #(.TONE_CYCLES(20), .BLINK_CYCLES(50), .SLOT_CYCLES(8)) mkp_scanner_inst (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .key_data_line_n(kd_n), .key_common_line_n(kc_n), .three_input_select_n(sel_n),
        .tone_group_link_n(link_n), .load_meter_input(lm), .speed_meter_input(sm),
        .tone_out(tone), .scan_indicator(scan_ind), .alarm_indicator(alarm), .irq(irq));
    mkp_key_panel mkp_key_panel_inst (.key_common_line_n(kc_n), .pressed(keys), .key_data_line_n(kd_n));
    // ------------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------------
    task automatic final_report();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            fails++;
        end
    endtask
    // one apb transfer; a spare edge after release keeps psel from two drives in one step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            final_report();
        end
        rv = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("register", e, rv);
    endtask
    task automatic watch(input int n);
        logic s;
        s = scan_ind;
        sc = 0;
        tc = 0;
        repeat (n) begin
            @(posedge pclk);
            sc += int'(scan_ind !== s);
            s = scan_ind;
            tc += int'(tone === 1'b1);
        end
    endtask
    // ------------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------------
    task automatic t_regs();
        rd(`MKP_OFS_CTRL, 32'h01);
        rd(`MKP_OFS_MASK, 32'h0);
        chk("alarm at start", 0, alarm);
        apb(1'b1, 12'h020, 32'hFF);
        chk("unmapped error", 1, er);
        rd(`MKP_OFS_STATE, 32'h13);
        lm <= 8'h57;
        sm <= 8'hFF;
        repeat (6) @(posedge pclk);
        rd(`MKP_OFS_METER, 32'hF850);
    endtask
    task automatic t_scan();
        keys[3*8+5] <= 1'b1;
        watch(2 * SCAN);
        chk("one common low", 1, $countones(~kc_n) == 1);
        rd(KEY + 12'd12, 32'h20);
        rd(KEY + 12'd16, 32'h0);
        keys <= '0;
    endtask
    task automatic t_ghost();
        keys[0] <= 1'b1;
        keys[9] <= 1'b1;
        watch(2 * SCAN);
        rd(KEY + 12'd4, 32'h02);
        keys[18] <= 1'b1;
        watch(2 * SCAN);
        rd(KEY, 32'h0);
        chk("alarm", 1, alarm);
        keys[18] <= 1'b0;
        watch(2 * SCAN);
        rd(KEY, 32'h01);
        chk("alarm", 0, alarm);
        sel_n <= 1'b0;
        keys[18] <= 1'b1;
        watch(2 * SCAN);
        rd(KEY + 12'd8, 32'h04);
        keys <= '0;
        sel_n <= 1'b1;
        watch(2 * SCAN);
    endtask
    task automatic t_tone();
        link_n <= 12'hFFF;
        keys[8] <= 1'b1;
        watch(2 * SCAN);
        chk("tone without enable", 0, tc);
        keys[8] <= 1'b0;
        watch(2 * SCAN);
        apb(1'b1, `MKP_OFS_CTRL, 32'h81);
        keys[15] <= 1'b1;
        watch(2 * SCAN);
        chk("tone length", 1, tc inside {20, 21});
        watch(2 * SCAN);
        chk("tone while held", 0, tc);
        keys[15] <= 1'b0;
        watch(2 * SCAN);
        chk("tone on release", 0, tc);
        keys[3] <= 1'b1;
        watch(2 * SCAN);
        chk("tone on linked common", 0, tc);
        keys <= '0;
        watch(2 * SCAN);
    endtask
    task automatic t_irq();
        apb(1'b1, `MKP_OFS_MASK, 32'h04);
        repeat (2) @(posedge pclk);
        chk("irq raised", 1, irq);
        apb(1'b1, `MKP_OFS_STATUS, 32'h04);
        repeat (2) @(posedge pclk);
        chk("irq cleared", 0, irq);
        apb(1'b1, `MKP_OFS_MASK, 32'h0);
    endtask
    task automatic t_halt();
        watch(120);
        chk("blink while scanning", 1, sc >= 2);
        apb(1'b1, `MKP_OFS_CTRL, 32'h0);
        watch(2 * SCAN);
        watch(120);
        chk("steady when halted", 0, sc);
        chk("commons released", 12'hFFF, kc_n);
    endtask
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_scan();
        t_ghost();
        t_tone();
        t_irq();
        t_halt();
        final_report();
    end
endmodule
